// ==== hw/fdr_relay.sv ====
// firmware download relay: pc to module uart bridge, ignition and restart control
// What this block does
// RULE_01 - module raises supply within 100 ms after ignition falls; relay only observes it
// RULE_02 - line toward module held high from reset onward, idle between characters
// RULE_03 - ready status shows only after supply rise plus internal boot wait
// RULE_04 - service connector plugged hands the module lines to the external port
// RULE_05 - while service connector plugged, relay stays passive and discards input; a restart sequence already running still drives power down and ignition
// RULE_06 - restart: power down low 3.5 s, then ignition pulse
// RULE_07 - every pc side character is retransmitted toward the module
// RULE_08 - every module side character is retransmitted toward the pc
// RULE_09 - forward with minimal delay and without dropping data
// RULE_10 - both ports run at 57600 or 115200 baud
// RULE_11 - pc to module buffer of at least 256 bytes
// RULE_12 - active dtr drives ignition to 0 V, inactive leaves it floating
// RULE_13 - relay must be enabled and forwarding before the pc transfer starts
// RULE_14 - same 8n1 framing on both ports, characters pass unaltered
`timescale 1ns/10ps
`include "fdr_params.svh"

module fdr_fifo #(
	parameter int WIDTH = `FDR_FIFO_WIDTH,
	parameter int DEPTH = `FDR_FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fdr_fifo_state_t;
	fdr_fifo_state_t q, d;
	logic push, pop;

	assign in_ready = (q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (q.cnt != '0);
	assign out_data = q.mem[q.rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + AW'(1);
		end
		if (pop) begin
			d.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + AW'(1);
		end
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule // fdr_fifo

module fdr_relay
	import fdr_pkg::*;
#(
	parameter int BAUD = `FDR_BAUD_FAST,
	parameter int FIFO_DEPTH = 256,
	parameter int PD_HOLD_CYC = `FDR_PD_HOLD_CYC,
	parameter int IGN_PULSE_CYC = `FDR_IGN_PULSE_CYC,
	parameter int BOOT_WAIT_CYC = `FDR_BOOT_WAIT_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic relay_enable,
	input wire logic restart_req,
	input wire logic pc_side_rx,
	output logic pc_side_tx,
	input wire logic pc_dtr_n,
	input wire logic module_side_rx,
	output logic module_side_tx,
	input wire logic module_supply,
	input wire logic service_plugged,
	output logic route_to_service,
	output logic ignition_line_out,
	output logic ignition_line_oe,
	output logic power_down_line_out,
	output logic power_down_line_oe,
	output logic module_ready,
	output logic data_lost
);
	localparam logic [15:0] BIT_CYC = 16'(`FDR_BIT_CYC(BAUD)); // see RULE_10
	localparam logic [15:0] HALF_CYC = 16'(`FDR_BIT_CYC(BAUD) / 2);
	localparam logic [3:0] STOP_IDX = 4'(`FDR_FRAME_BITS - 1); // see RULE_14

	typedef struct packed {
		logic [1:0] pcrx_s;
		logic [1:0] mrx_s;
		logic [1:0] dtr_s;
		logic [1:0] svc_s;
		logic [1:0] vdd_s;
		logic vdd_prev;
		logic [1:0] rx_busy;
		logic [1:0][15:0] rx_cnt;
		logic [1:0][3:0] rx_bit;
		logic [1:0][7:0] rx_sh;
		logic [1:0] tx_busy;
		logic [1:0][15:0] tx_cnt;
		logic [1:0][3:0] tx_bit;
		logic [1:0][9:0] tx_sh;
		logic [1:0] tx_line;
		logic hold_v;
		logic [7:0] hold_d;
		fdr_seq_t seq;
		logic [31:0] seq_cnt;
		logic [31:0] boot_cnt;
		logic ready;
		logic ign_oe;
		logic pd_oe;
		logic route_svc;
		logic lost;
	} fdr_relay_state_t;

	fdr_relay_state_t q, d;
	logic [1:0] rx_done;
	logic [1:0] tx_load;
	logic [1:0] rx_in;
	logic [1:0][7:0] tx_data;
	logic fwd;
	logic [1:0] tx_free;
	logic f_in_ready, f_out_valid, f_out_ready;
	logic [7:0] f_out_data;

	// a queued byte may start in the last stop-bit cycle; an idle cycle per frame
	// would let the sender drift ahead and overrun the holding byte on long bursts
	function automatic logic tx_can_load(input logic busy, input logic [15:0] cnt,
		input logic [3:0] idx);
		return !busy || (cnt == '0 && idx == STOP_IDX);
	endfunction

	// forwarding only when enabled and the service port is not in charge
	assign fwd = relay_enable & ~q.svc_s[1]; // see RULE_05 see RULE_13
	assign rx_in = {q.mrx_s[1], q.pcrx_s[1]};
	assign tx_free[0] = tx_can_load(q.tx_busy[0], q.tx_cnt[0], q.tx_bit[0]); // see RULE_09
	assign tx_free[1] = tx_can_load(q.tx_busy[1], q.tx_cnt[1], q.tx_bit[1]); // see RULE_09
	assign f_out_ready = tx_free[0] & fwd;
	assign tx_load = {q.hold_v & tx_free[1] & fwd, f_out_valid & f_out_ready};
	assign tx_data = {q.hold_d, f_out_data};

	fdr_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_pc2mod_fifo (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.in_valid(rx_done[0]), // see RULE_07 see RULE_11
		.in_ready(f_in_ready),
		.in_data(q.rx_sh[0]),
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out_data)
	);

	always_comb begin
		d = q;
		rx_done = '0;
		// pins are double-flopped; only the second stage feeds logic
		d.pcrx_s = {q.pcrx_s[0], pc_side_rx};
		d.mrx_s = {q.mrx_s[0], module_side_rx};
		d.dtr_s = {q.dtr_s[0], pc_dtr_n};
		d.svc_s = {q.svc_s[0], service_plugged};
		d.vdd_s = {q.vdd_s[0], module_supply};
		d.vdd_prev = q.vdd_s[1];
		d.route_svc = q.svc_s[1]; // see RULE_04

		for (int i = 0; i < 2; i++) begin
			// receivers: mid-bit sampling, false starts rejected
			if (!q.rx_busy[i]) begin
				if (!rx_in[i] && fwd) begin
					d.rx_busy[i] = 1'b1;
					d.rx_cnt[i] = HALF_CYC;
					d.rx_bit[i] = '0;
				end
			end else if (q.rx_cnt[i] != '0) begin
				d.rx_cnt[i] = q.rx_cnt[i] - 16'h0001;
			end else if (q.rx_bit[i] == '0) begin
				d.rx_busy[i] = ~rx_in[i];
				d.rx_bit[i] = 4'h1;
				d.rx_cnt[i] = BIT_CYC - 16'h0001;
			end else if (q.rx_bit[i] != STOP_IDX) begin
				d.rx_sh[i] = {rx_in[i], q.rx_sh[i][7:1]};
				d.rx_bit[i] = q.rx_bit[i] + 4'h1;
				d.rx_cnt[i] = BIT_CYC - 16'h0001;
			end else begin
				// a framing error drops the character
				d.rx_busy[i] = 1'b0;
				rx_done[i] = rx_in[i];
			end
			// transmitters: line idles high from reset on
			if (tx_load[i]) begin
				d.tx_busy[i] = 1'b1;
				d.tx_sh[i] = {1'b1, tx_data[i], 1'b0}; // see RULE_14
				d.tx_line[i] = 1'b0;
				d.tx_bit[i] = '0;
				d.tx_cnt[i] = BIT_CYC - 16'h0001;
			end else if (q.tx_busy[i]) begin
				if (q.tx_cnt[i] != '0) begin
					d.tx_cnt[i] = q.tx_cnt[i] - 16'h0001;
				end else if (q.tx_bit[i] == STOP_IDX) begin
					d.tx_busy[i] = 1'b0;
					d.tx_line[i] = 1'b1; // see RULE_02
				end else begin
					d.tx_sh[i] = {1'b1, q.tx_sh[i][9:1]};
					d.tx_line[i] = q.tx_sh[i][1];
					d.tx_bit[i] = q.tx_bit[i] + 4'h1;
					d.tx_cnt[i] = BIT_CYC - 16'h0001;
				end
			end
		end

		// module to pc: single holding byte is enough at equal baud rates
		if (tx_load[1]) begin
			d.hold_v = 1'b0;
		end
		if (rx_done[1]) begin
			d.hold_v = 1'b1; // see RULE_08
			d.hold_d = q.rx_sh[1];
		end
		// loss is flagged, never silent; cleared only by reset
		if ((rx_done[1] && q.hold_v && !tx_load[1]) || (rx_done[0] && !f_in_ready)) begin
			d.lost = 1'b1; // see RULE_09
		end

		// restart sequencer
		unique case (q.seq)
			FDR_SEQ_IDLE: begin
				if (restart_req && !q.svc_s[1]) begin
					d.seq = FDR_SEQ_PD;
					d.seq_cnt = 32'(PD_HOLD_CYC - 1);
				end
			end
			FDR_SEQ_PD: begin
				if (q.seq_cnt == '0) begin
					d.seq = FDR_SEQ_IGN;
					d.seq_cnt = 32'(IGN_PULSE_CYC - 1);
				end else begin
					d.seq_cnt = q.seq_cnt - 32'h0000_0001;
				end
			end
			FDR_SEQ_IGN: begin
				if (q.seq_cnt == '0) begin
					d.seq = FDR_SEQ_IDLE;
				end else begin
					d.seq_cnt = q.seq_cnt - 32'h0000_0001;
				end
			end
			default: begin
				d.seq = FDR_SEQ_IDLE;
			end
		endcase
		d.pd_oe = (d.seq == FDR_SEQ_PD); // see RULE_06
		// dtr is active low at cmos level; ignition is open drain
		d.ign_oe = (d.seq == FDR_SEQ_IGN) || (fwd && !q.dtr_s[1]); // see RULE_12

		// boot wait after supply rise before the link is usable
		if (!q.vdd_s[1]) begin
			d.ready = 1'b0;
			d.boot_cnt = '0;
		end else if (q.vdd_s[1] && !q.vdd_prev) begin
			d.boot_cnt = 32'(BOOT_WAIT_CYC - 1);
			d.ready = 1'b0;
		end else if (q.boot_cnt != '0) begin
			d.boot_cnt = q.boot_cnt - 32'h0000_0001;
		end else if (!q.ready) begin
			d.ready = 1'b1; // see RULE_03 see RULE_01
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
			q.pcrx_s <= 2'h3;
			q.mrx_s <= 2'h3;
			q.dtr_s <= 2'h3;
			q.tx_line <= 2'h3;
			q.tx_sh <= '1;
			q.seq <= FDR_SEQ_IDLE;
		end else begin
			q <= d;
		end
	end

	assign pc_side_tx = q.tx_line[1];
	assign module_side_tx = q.tx_line[0];
	assign ignition_line_out = 1'b0;
	assign ignition_line_oe = q.ign_oe;
	assign power_down_line_out = 1'b0;
	assign power_down_line_oe = q.pd_oe;
	assign route_to_service = q.route_svc;
	assign module_ready = q.ready;
	assign data_lost = q.lost;

	a_tx_idle_high: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE_02
		!q.tx_busy[0] |-> module_side_tx)
		else $error("module side line not high while idle");
	a_ign_passive_svc: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE_05
		(q.svc_s[1] && q.seq == FDR_SEQ_IDLE) |=> !ignition_line_oe)
		else $error("ignition driven while service port plugged");
	a_ign_follow_dtr: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE_12
		(fwd && !q.dtr_s[1]) |=> ignition_line_oe)
		else $error("active dtr did not pull ignition low");
	a_pd_then_ign: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE_06
		$fell(power_down_line_oe) |-> ignition_line_oe)
		else $error("power down release not followed by ignition");
	a_pd_start: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE_06
		(q.seq == FDR_SEQ_IDLE && restart_req && !q.svc_s[1]) |=> power_down_line_oe)
		else $error("restart request did not pull power down");
	a_m2p_forward: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE_08
		(rx_done[1] && fwd) |=> q.hold_v && q.hold_d == $past(q.rx_sh[1]))
		else $error("module character not captured for the pc");
	a_p2m_start: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE_07
		tx_load[0] |=> !module_side_tx && q.tx_sh[0][8:1] == $past(f_out_data))
		else $error("pc character not started toward module");
	a_route_svc: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE_04
		q.svc_s[1] |=> route_to_service)
		else $error("service connector not given priority");
	a_ready_wait: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE_03
		$rose(q.vdd_s[1]) |=> !module_ready [*2])
		else $error("ready shown before boot wait");
	a_no_silent_loss: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE_09
		(rx_done[0] && !f_in_ready) |=> data_lost)
		else $error("dropped pc character not flagged");
	a_no_hold_loss: assert property (@(posedge clk_sys) disable iff (sys_rst) // see RULE_09
		(rx_done[1] && q.hold_v && !tx_load[1]) |=> data_lost)
		else $error("overwritten module character not flagged");
endmodule // fdr_relay

// ==== pkg/fdr_params.svh ====
// timing and framing constants of the firmware download relay
`ifndef FDR_PARAMS_SVH
`define FDR_PARAMS_SVH
`define FDR_CLK_HZ 200000000
`define FDR_BAUD_FAST 115200
`define FDR_BAUD_SLOW 57600
`define FDR_DATA_BITS 8
`define FDR_FRAME_BITS 10
`define FDR_BIT_CYC(baud) ((`FDR_CLK_HZ) / (baud))
`define FDR_PD_HOLD_MS 3500
`define FDR_PD_HOLD_CYC ((`FDR_PD_HOLD_MS) * ((`FDR_CLK_HZ) / 1000))
`define FDR_IGN_PULSE_MS 100
`define FDR_IGN_PULSE_CYC ((`FDR_IGN_PULSE_MS) * ((`FDR_CLK_HZ) / 1000))
`define FDR_BOOT_WAIT_MS 50
`define FDR_BOOT_WAIT_CYC ((`FDR_BOOT_WAIT_MS) * ((`FDR_CLK_HZ) / 1000))
`define FDR_FIFO_DEPTH 16
`define FDR_FIFO_WIDTH 8
`endif

// ==== pkg/fdr_pkg.sv ====
// types of the firmware download relay
package fdr_pkg;
	typedef enum logic [1:0] {
		FDR_SEQ_IDLE = 2'h0,
		FDR_SEQ_PD = 2'h1,
		FDR_SEQ_IGN = 2'h3
	} fdr_seq_t;
endpackage

// ==== verif/fdr_peer_model.sv ====
// serial peer model standing in for the pc download tool or the cellular module
`timescale 1ns/10ps
module fdr_peer_model #(
	parameter int BIT = 20,
	parameter int SUP_DLY = 40
) (
	input wire logic clk_sys,
	input wire logic rx_line,
	output logic tx_line,
	input wire logic ign_low,
	input wire logic pd_low,
	output logic supply
);
	logic [7:0] rxq[$];
	logic [7:0] b;
	int n;
	initial begin
		tx_line = 1'b1;
		supply = 1'b0;
		n = 0;
	end
	// supply comes up well inside the allowed span after ignition is pulled low
	always @(posedge clk_sys) begin
		n <= ign_low ? n + 1 : 0;
		if (pd_low)
			supply <= 1'b0;
		else if (n == SUP_DLY)
			supply <= 1'b1;
	end
	// 8n1 receive, lsb first, sampled mid-bit; a low stop bit drops the character
	initial forever begin
		@(negedge rx_line);
		repeat (BIT / 2) @(posedge clk_sys);
		if (!rx_line) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge clk_sys);
				b[i] = rx_line;
			end
			repeat (BIT) @(posedge clk_sys);
			if (rx_line)
				rxq.push_back(b);
		end
	end
	// line stays high between characters, as the pull-up would leave it
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clk_sys);
			tx_line = f[i];
			repeat (BIT - 1) @(negedge clk_sys);
		end
	endtask
endmodule // fdr_peer_model

// ==== verif/tb_fdr_relay.sv ====
// self-checking bench of the download relay with serial peers and a buffer check
`timescale 1ns/10ps
module tb_fdr_relay;
	localparam int BIT = 20;
	localparam int PD = 200;
	localparam int IGN = 50;
	localparam int BOOT = 30;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic en = 1'b0;
	logic rst_req = 1'b0;
	logic dtr_n = 1'b1;
	logic svc = 1'b0;
	logic pc_rx, pc_tx, m_rx, m_tx, sup, route, ign_out, ign_oe, pd_out, pd_oe, rdy, lost;
	logic [7:0] exp_q[$];
	int error_cnt = 0;
	int tests_run = 0;
	int n;
	always #2.5 clk_sys = ~clk_sys;
	// relay and both peers share one bit period
	fdr_relay #(.BAUD(10000000), .PD_HOLD_CYC(PD), .IGN_PULSE_CYC(IGN),
		.BOOT_WAIT_CYC(BOOT)) fdr_relay_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.relay_enable(en), .restart_req(rst_req), .pc_side_rx(pc_rx), .pc_side_tx(pc_tx),
		.pc_dtr_n(dtr_n), .module_side_rx(m_rx), .module_side_tx(m_tx), .module_supply(sup),
		.service_plugged(svc), .route_to_service(route), .ignition_line_out(ign_out),
		.ignition_line_oe(ign_oe), .power_down_line_out(pd_out), .power_down_line_oe(pd_oe),
		.module_ready(rdy), .data_lost(lost));
	fdr_peer_model #(.BIT(BIT)) pc_peer (.clk_sys(clk_sys), .rx_line(pc_tx),
		.tx_line(pc_rx), .ign_low(1'b0), .pd_low(1'b0), .supply());
	fdr_peer_model #(.BIT(BIT)) mod_peer (.clk_sys(clk_sys), .rx_line(m_tx),
		.tx_line(m_rx), .ign_low(ign_oe & !ign_out), .pd_low(pd_oe & !pd_out), .supply(sup));
	function automatic logic exp_ign(input logic e, input logic d_n, input logic s);
		return e & !d_n & !s;
	endfunction
	task automatic chk_bit(input logic got, input logic exp, input string what);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s", $time, what);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s", $time, what);
		end
	endtask
	task automatic complete_run();
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask
	// corner bytes first, then random ones, all back to back at line rate
	task automatic xfer(input bit to_mod, input int cnt);
		logic [7:0] d;
		exp_q = {};
		for (int i = 0; i < cnt; i++) begin
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			exp_q.push_back(d);
			if (to_mod)
				pc_peer.send(d);
			else
				mod_peer.send(d);
		end
		n = 0;
		while (n < 2000 && (to_mod ? mod_peer.rxq.size() : pc_peer.rxq.size()) < cnt) begin
			cyc(1);
			n++;
		end
		chk_bit(n < 2000, 1'b1, "bytes missing");
		for (int i = 0; i < cnt && i < exp_q.size(); i++) begin
			d = to_mod ? mod_peer.rxq.pop_front() : pc_peer.rxq.pop_front();
			chk_byte(d, exp_q[i], "forwarded byte");
		end
	endtask
	initial begin
		repeat (30000) @(posedge clk_sys);
		error_cnt++;
		complete_run();
	end
	initial begin
		void'($urandom(46));
		repeat (16) @(posedge clk_sys);
		@(negedge clk_sys);
		sys_rst = 1'b0;
		chk_bit(m_tx, 1'b1, "tx idle level");
		chk_bit(ign_oe | pd_oe | rdy, 1'b0, "reset outputs");
		pc_peer.send(8'h5a);
		cyc(300);
		chk_bit(mod_peer.rxq.size() == 0, 1'b1, "forwarded while disabled");
		en = 1'b1;
		cyc(4);
		xfer(1'b1, 8);
		xfer(1'b0, 8);
		dtr_n = 1'b0;
		cyc(5);
		chk_bit(ign_oe & !ign_out, exp_ign(en, dtr_n, svc), "ignition pull");
		n = 0;
		while (sup !== 1'b1 && n < 100) begin
			cyc(1);
			n++;
		end
		// two synchroniser stages, one edge to load the wait, then the wait itself
		cyc(BOOT + 2);
		chk_bit(rdy, 1'b0, "ready too early");
		cyc(1);
		chk_bit(rdy, 1'b1, "ready missing");
		dtr_n = 1'b1;
		cyc(5);
		chk_bit(ign_oe, exp_ign(en, dtr_n, svc), "ignition release");
		svc = 1'b1;
		dtr_n = 1'b0;
		cyc(5);
		chk_bit(route, 1'b1, "route to service");
		chk_bit(ign_oe, exp_ign(en, dtr_n, svc), "passive ignition");
		pc_peer.send(8'($urandom));
		cyc(450);
		chk_bit(mod_peer.rxq.size() == 0, 1'b1, "forwarded while service");
		svc = 1'b0;
		dtr_n = 1'b1;
		cyc(5);
		chk_bit(route, 1'b0, "route back");
		rst_req = 1'b1;
		cyc(1);
		rst_req = 1'b0;
		chk_bit(pd_oe & !pd_out, 1'b1, "power down pull");
		n = 0;
		while (pd_oe === 1'b1 && n < 1000) begin
			n++;
			cyc(1);
		end
		chk_bit(n == PD, 1'b1, "power down hold");
		chk_bit(rdy, 1'b0, "ready after power down");
		n = 0;
		while (ign_oe === 1'b1 && n < 1000) begin
			n++;
			cyc(1);
		end
		chk_bit(n == IGN, 1'b1, "ignition pulse");
		// long back-to-back bursts, pc to module through the relay buffer, module to pc through the holding byte
		xfer(1'b1, 20);
		chk_bit(pc_peer.rxq.size() == 0, 1'b1, "echo toward pc");
		xfer(1'b0, 12);
		cyc(2);
		chk_bit(m_tx & pc_tx, 1'b1, "idle after burst");
		chk_bit(lost, 1'b0, "data lost");
		complete_run();
	end
endmodule // tb_fdr_relay
